//--- logic/inhibit_params.svh
// Constants for the display blanking and key scan control block
`ifndef INHIBIT_PARAMS_SVH
`define INHIBIT_PARAMS_SVH

`define SEG_COUNT        60
`define COM_COUNT        10
`define PORT_COUNT       4
`define KEY_COLS         6
`define KEY_ROWS         5
`define KEY_BITS         30
`define COL_IDX_W        3
`define BIT_CNT_W        5

// Write frame: direction bit, then port bits, scan standby bits, seg off
`define WR_PAYLOAD_BITS  11
`define WR_FRAME_BITS    5'h0C
`define DIR_READ         1'b1
`define PC_LSB           7
`define KC_LSB           1
`define SC_BIT           0

`define PORT_RESET       4'h0
`define KC_RESET         6'h00
`define KEY_DATA_RESET   30'h00000000
`define LAST_COL         3'h5
`define ROW_STEP         3'h5

// Time that one key scan column is driven, in ns, and its cycle count
`define CLK_PERIOD_NS    10
`define SCAN_STEP_NS     2560
`define SCAN_STEP_CYC    (`SCAN_STEP_NS / `CLK_PERIOD_NS)
`define STEP_CNT_W       9

`endif

//--- logic/inhibit_pkg.sv
// Types shared by the display blanking and key scan control block
package inhibit_pkg;

  typedef enum logic [1:0] {
    SER_IDLE  = 2'h0,
    SER_DIR   = 2'h1,
    SER_WRITE = 2'h3,
    SER_READ  = 2'h2
  } ser_state_t;

endpackage : inhibit_pkg

//--- logic/sync2.sv
// Two flip-flop synchroniser for pin inputs
module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] reset_val_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // Reset to zero; output XORed with reset_val_in, so callers only invert the input for another idle level
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q ^ reset_val_in;

endmodule : sync2

//--- logic/display_inhibit_control.sv
// Display blanking pin control with serial link and key scan
`include "inhibit_params.svh"

module display_inhibit_control
  import inhibit_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  rstn_in,
  input  wire logic                  display_blank_pin_n_in,
  input  wire logic                  chip_enable_in,
  input  wire logic                  serial_shift_strobe_in,
  input  wire logic                  serial_data_in,
  input  wire logic [`KEY_ROWS-1:0]  key_return_in,
  output logic                       serial_data_out,
  output logic                       serial_data_oe_n_out,
  output logic                       display_on_out,
  output logic                       segment_off_wave_out,
  output logic [`SEG_COUNT-1:0]      segment_outputs_lowbias_out,
  output logic [`COM_COUNT-1:0]      backplane_drivers_lowbias_out,
  output logic [`PORT_COUNT-1:0]     general_outputs_out,
  output logic [`KEY_COLS-1:0]       key_scan_outputs_out,
  output logic [`KEY_BITS-1:0]       key_data_out
);

  // Synchronised pins
  logic                 blank_n_s;
  logic                 ce_s;
  logic                 strobe_s;
  logic                 din_s;
  logic [`KEY_ROWS-1:0] rows_s;

  // Blank pin idles high, so its synchroniser output is inverted back
  // Two stages then one register
  sync2 #(.WIDTH(1)) u_sync_blank (
    .clk_in       (clk_in),
    .rstn_in      (rstn_in),
    .async_in     (~display_blank_pin_n_in),
    .reset_val_in (1'b1),
    .sync_out     (blank_n_s)
  );

  // Link pins sampled on the system clock
  sync2 #(.WIDTH(3 + `KEY_ROWS)) u_sync_link (
    .clk_in       (clk_in),
    .rstn_in      (rstn_in),
    .async_in     ({chip_enable_in, serial_shift_strobe_in,
                    serial_data_in, key_return_in}),
    .reset_val_in ('0),
    .sync_out     ({ce_s, strobe_s, din_s, rows_s})
  );

  // Edge detection on synchronised link signals
  logic ce_prev_q;
  logic strobe_prev_q;
  logic ce_prev_d;
  logic strobe_prev_d;
  logic ce_rise;
  logic ce_fall;
  logic strobe_rise;
  logic strobe_fall;

  always_comb begin
    ce_prev_d     = ce_s;
    strobe_prev_d = strobe_s;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ce_prev_q     <= 1'b0;
      strobe_prev_q <= 1'b0;
    end else begin
      ce_prev_q     <= ce_prev_d;
      strobe_prev_q <= strobe_prev_d;
    end
  end

  assign ce_rise     = ce_s & ~ce_prev_q;
  assign ce_fall     = ~ce_s & ce_prev_q;
  assign strobe_rise = strobe_s & ~strobe_prev_q & ce_s;
  assign strobe_fall = ~strobe_s & strobe_prev_q & ce_s;

  // Serial frame engine
  ser_state_t                  ser_state_q;
  ser_state_t                  ser_state_d;
  logic [`BIT_CNT_W-1:0]       bit_cnt_q;
  logic [`BIT_CNT_W-1:0]       bit_cnt_d;
  logic [`WR_PAYLOAD_BITS-1:0] rx_shift_q;
  logic [`WR_PAYLOAD_BITS-1:0] rx_shift_d;
  logic [`KEY_BITS-1:0]        tx_shift_q;
  logic [`KEY_BITS-1:0]        tx_shift_d;
  logic                        dout_oe_n_q;
  logic                        dout_oe_n_d;
  logic [`PORT_COUNT-1:0]      port_bits_q;
  logic [`PORT_COUNT-1:0]      port_bits_d;
  logic [`KEY_COLS-1:0]        kc_bits_q;
  logic [`KEY_COLS-1:0]        kc_bits_d;
  logic                        sc_bit_q;
  logic                        sc_bit_d;
  logic [`KEY_BITS-1:0]        key_data_q;

  always_comb begin
    ser_state_d = ser_state_q;
    bit_cnt_d   = bit_cnt_q;
    rx_shift_d  = rx_shift_q;
    tx_shift_d  = tx_shift_q;
    dout_oe_n_d = dout_oe_n_q;
    port_bits_d = port_bits_q;
    kc_bits_d   = kc_bits_q;
    sc_bit_d    = sc_bit_q;
    // Frame handling ignores the blank pin entirely
    case (ser_state_q)
      SER_IDLE: begin
        dout_oe_n_d = 1'b1;
        if (ce_rise) begin
          ser_state_d = SER_DIR;
          bit_cnt_d   = '0;
        end
      end
      SER_DIR: begin
        if (ce_fall) begin
          ser_state_d = SER_IDLE;
        end else if (strobe_rise) begin
          bit_cnt_d = bit_cnt_q + 5'h01;
          if (din_s == `DIR_READ) begin
            // Key data snapshot for the read frame
            ser_state_d = SER_READ;
            tx_shift_d  = key_data_q;
          end else begin
            ser_state_d = SER_WRITE;
          end
        end
      end
      SER_WRITE: begin
        if (ce_fall) begin
          ser_state_d = SER_IDLE;
          // Short or long frames are dropped to keep old settings
          if (bit_cnt_q == `WR_FRAME_BITS) begin
            // Port state bits latched at frame end
            port_bits_d = rx_shift_q[`PC_LSB +: `PORT_COUNT];
            kc_bits_d   = rx_shift_q[`KC_LSB +: `KEY_COLS];
            sc_bit_d    = rx_shift_q[`SC_BIT];
          end
        end else if (strobe_rise) begin
          // Data taken from the serial input pin
          rx_shift_d = {rx_shift_q[`WR_PAYLOAD_BITS-2:0], din_s};
          if (bit_cnt_q != {`BIT_CNT_W{1'b1}}) begin
            bit_cnt_d = bit_cnt_q + 5'h01;
          end
        end
      end
      SER_READ: begin
        if (ce_fall) begin
          ser_state_d = SER_IDLE;
          dout_oe_n_d = 1'b1;
        end else if (strobe_fall) begin
          // Open drain: pull low for a zero, release for a one
          dout_oe_n_d = tx_shift_q[`KEY_BITS-1];
          tx_shift_d  = {tx_shift_q[`KEY_BITS-2:0], 1'b0};
        end
      end
      default: begin
        ser_state_d = SER_IDLE;
        dout_oe_n_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ser_state_q <= SER_IDLE;
      bit_cnt_q   <= '0;
      rx_shift_q  <= '0;
      tx_shift_q  <= '0;
      dout_oe_n_q <= 1'b1;
      port_bits_q <= `PORT_RESET;
      kc_bits_q   <= `KC_RESET;
      sc_bit_q    <= 1'b0;
    end else begin
      ser_state_q <= ser_state_d;
      bit_cnt_q   <= bit_cnt_d;
      rx_shift_q  <= rx_shift_d;
      tx_shift_q  <= tx_shift_d;
      dout_oe_n_q <= dout_oe_n_d;
      port_bits_q <= port_bits_d;
      kc_bits_q   <= kc_bits_d;
      sc_bit_q    <= sc_bit_d;
    end
  end

  // Key scanner
  logic [`STEP_CNT_W-1:0] step_cnt_q;
  logic [`STEP_CNT_W-1:0] step_cnt_d;
  logic [`COL_IDX_W-1:0]  col_q;
  logic [`COL_IDX_W-1:0]  col_d;
  logic [`KEY_BITS-1:0]   key_data_d;
  logic [`KEY_COLS-1:0]   scan_out_q;
  logic [`KEY_COLS-1:0]   scan_out_d;
  logic                   step_done;
  logic [`BIT_CNT_W-1:0]  col_base;

  // Widened so the last column's base of 25 does not wrap
  assign col_base = `BIT_CNT_W'(col_q) * `BIT_CNT_W'(`ROW_STEP);

  assign step_done = (step_cnt_q ==
                      `STEP_CNT_W'(`SCAN_STEP_CYC - 1));

  always_comb begin
    step_cnt_d = step_cnt_q;
    col_d      = col_q;
    key_data_d = key_data_q;
    scan_out_d = '0;
    if (!blank_n_s) begin
      // Scanning halted, scan outputs held low
      step_cnt_d = '0;
      col_d      = '0;
      scan_out_d = '0;
      // Stored key data cleared while blanked
      key_data_d = `KEY_DATA_RESET;
    end else begin
      // Columns driven in turn, rows recorded
      scan_out_d        = '0;
      scan_out_d[col_q] = kc_bits_q[col_q];
      step_cnt_d        = step_cnt_q + `STEP_CNT_W'(1);
      if (step_done) begin
        step_cnt_d = '0;
        // Undriven columns record no press, so their keys read zero
        key_data_d[col_base +: `KEY_ROWS] =
          rows_s & {`KEY_ROWS{kc_bits_q[col_q]}};
        col_d = (col_q == `LAST_COL) ? '0 : col_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      step_cnt_q <= '0;
      col_q      <= '0;
      key_data_q <= `KEY_DATA_RESET;
      scan_out_q <= '0;
    end else begin
      step_cnt_q <= step_cnt_d;
      col_q      <= col_d;
      key_data_q <= key_data_d;
      scan_out_q <= scan_out_d;
    end
  end

  // Display and port outputs
  logic                   disp_on_q;
  logic                   disp_on_d;
  logic [`PORT_COUNT-1:0] ports_q;
  logic [`PORT_COUNT-1:0] ports_d;

  always_comb begin
    // Blanked display: all drivers to lowest bias
    disp_on_d = blank_n_s;
    // Ports follow their state bits when released
    ports_d   = blank_n_s ? port_bits_q : '0;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      disp_on_q <= 1'b0;
      ports_q   <= '0;
    end else begin
      disp_on_q <= disp_on_d;
      ports_q   <= ports_d;
    end
  end

  assign display_on_out                = disp_on_q;
  assign segment_off_wave_out          = disp_on_q & sc_bit_q;
  assign segment_outputs_lowbias_out   = {`SEG_COUNT{~disp_on_q}};
  assign backplane_drivers_lowbias_out = {`COM_COUNT{~disp_on_q}};
  assign general_outputs_out           = ports_q;
  assign key_scan_outputs_out          = scan_out_q;
  assign key_data_out                  = key_data_q;
  assign serial_data_out               = 1'b0;
  assign serial_data_oe_n_out          = dout_oe_n_q;

endmodule : display_inhibit_control

//--- tb/inhibit_assertions.sv
// Checker for the blanking pin effects at the block ports
`include "inhibit_params.svh"
module inhibit_checker (
  input wire logic                 clk_in,
  input wire logic                 rstn_in,
  input wire logic                 display_blank_pin_n_in,
  input wire logic                 chip_enable_in,
  input wire logic                 serial_shift_strobe_in,
  input wire logic                 serial_data_in,
  input wire logic [`KEY_ROWS-1:0] key_return_in,
  input wire logic                 serial_data_out,
  input wire logic                 serial_data_oe_n_out,
  input wire logic                 display_on_out,
  input wire logic                 segment_off_wave_out,
  input wire logic [`SEG_COUNT-1:0] segment_outputs_lowbias_out,
  input wire logic [`COM_COUNT-1:0] backplane_drivers_lowbias_out,
  input wire logic [`PORT_COUNT-1:0] general_outputs_out,
  input wire logic [`KEY_COLS-1:0] key_scan_outputs_out,
  input wire logic [`KEY_BITS-1:0] key_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  // Four samples cover two sync stages and the output register
  sequence blank_held;
    (!display_blank_pin_n_in) [*4];
  endsequence
  sequence shown_held;
    display_blank_pin_n_in [*4];
  endsequence
  a_blank_drivers:
    assert property (blank_held |-> !display_on_out && !segment_off_wave_out
      && (&segment_outputs_lowbias_out) && (&backplane_drivers_lowbias_out))
    else $error("drivers not at lowest bias while blanked");
  a_blank_ports:
    assert property (blank_held |-> general_outputs_out == 4'h0)
    else $error("general outputs not low while blanked");
  a_blank_scan:
    assert property (blank_held |-> key_scan_outputs_out == 6'h00)
    else $error("key scan outputs not low while blanked");
  a_blank_keys:
    assert property (blank_held |-> key_data_out == 30'h00000000)
    else $error("key data not cleared while blanked");
  a_shown_drivers:
    assert property (shown_held |-> display_on_out
      && segment_outputs_lowbias_out == 60'h0
      && backplane_drivers_lowbias_out == 10'h000)
    else $error("display not on with pin high");
  a_scan_onehot:
    assert property ($onehot0(key_scan_outputs_out))
    else $error("more than one key scan column driven");
  a_dout_low:
    assert property (serial_data_out == 1'b0)
    else $error("open drain data value not low");
  a_oe_idle:
    assert property ((!chip_enable_in) [*6] |-> serial_data_oe_n_out)
    else $error("data line held low outside a frame");
  a_release_lag:
    assert property (blank_held ##1 display_blank_pin_n_in |-> !display_on_out)
    else $error("display came on before pin was synchronised");
endmodule : inhibit_checker

bind display_inhibit_control inhibit_checker u_chk (.clk_in(clk_in),
  .rstn_in(rstn_in), .display_blank_pin_n_in(display_blank_pin_n_in),
  .chip_enable_in(chip_enable_in),
  .serial_shift_strobe_in(serial_shift_strobe_in),
  .serial_data_in(serial_data_in), .key_return_in(key_return_in),
  .serial_data_out(serial_data_out),
  .serial_data_oe_n_out(serial_data_oe_n_out),
  .display_on_out(display_on_out),
  .segment_off_wave_out(segment_off_wave_out),
  .segment_outputs_lowbias_out(segment_outputs_lowbias_out),
  .backplane_drivers_lowbias_out(backplane_drivers_lowbias_out),
  .general_outputs_out(general_outputs_out),
  .key_scan_outputs_out(key_scan_outputs_out),
  .key_data_out(key_data_out));

//--- tb/serial_host.sv
// System controller model driving the serial link
`include "inhibit_params.svh"
module serial_host (
  input  wire logic clk_in,
  input  wire logic line_in,
  output logic      ce_out,
  output logic      strobe_out,
  output logic      din_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ce_out = 1'b0;
    strobe_out = 1'b0;
    din_out = 1'b0;
  end
  task automatic send(input logic [12:0] bits, input int n);
    @(posedge clk_in) #1;
    ce_out = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      din_out = bits[i];
      #40 strobe_out = 1'b1;
      #40 strobe_out = 1'b0;
    end
    #40 ce_out = 1'b0;
    din_out = ~din_out;
    #80;
  endtask : send
  task automatic fetch(output logic [`KEY_BITS-1:0] k);
    @(posedge clk_in) #1;
    ce_out = 1'b1;
    din_out = `DIR_READ;
    #40 strobe_out = 1'b1;
    #40 strobe_out = 1'b0;
    for (int i = `KEY_BITS - 1; i >= 0; i--) begin
      #40 strobe_out = 1'b1;
      #20 k[i] = line_in;
      #20 strobe_out = 1'b0;
    end
    #40 ce_out = 1'b0;
    din_out = ~din_out;
    #80;
  endtask : fetch
endmodule : serial_host

//--- tb/display_inhibit_control_bench.sv
// Self-checking bench for the display blanking control block
`include "inhibit_params.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, g, e); end end
module display_inhibit_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        blank_n = 1'b1;
  logic [4:0]  rows = 5'h00;
  logic [29:0] keys = 30'h0;
  logic [31:0] seed = 32'h8D51;
  int          bad_count = 0;
  int          total_checks = 0;
  int          exp_port = 0;
  logic        ce, strobe, din, dout, oe_n, on, segoff;
  logic [59:0] segs;
  logic [9:0]  bp;
  logic [3:0]  gp;
  logic [5:0]  scan;
  logic [29:0] kd;
  wire         line = oe_n ? 1'b1 : dout;
  always #5 clk_in = ~clk_in;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // Key matrix: a pressed key joins its column to its row
  function automatic logic [4:0] ret(input logic [5:0] s,
                                     input logic [29:0] k);
    logic [4:0] r;
    r = 5'h00;
    for (int c = 0; c < 6; c++)
      if (s[c]) r |= k[c*5 +: 5];
    return r;
  endfunction : ret
  always @(posedge clk_in) rows <= #1 ret(scan, keys);
  display_inhibit_control u_dut (.clk_in(clk_in), .rstn_in(rstn_in),
    .display_blank_pin_n_in(blank_n), .chip_enable_in(ce),
    .serial_shift_strobe_in(strobe), .serial_data_in(din),
    .key_return_in(rows), .serial_data_out(dout),
    .serial_data_oe_n_out(oe_n), .display_on_out(on),
    .segment_off_wave_out(segoff), .segment_outputs_lowbias_out(segs),
    .backplane_drivers_lowbias_out(bp), .general_outputs_out(gp),
    .key_scan_outputs_out(scan), .key_data_out(kd));
  serial_host u_host (.clk_in(clk_in), .line_in(line), .ce_out(ce),
    .strobe_out(strobe), .din_out(din));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic wr(input int p, input logic sc);
    u_host.send({2'b00, 4'(p), 6'h3F, sc}, 12);
    // Model keeps the last accepted port bits
    exp_port = p;
    repeat (8) @(posedge clk_in);
  endtask : wr
  task automatic pin(input logic v);
    @(posedge clk_in) #1 blank_n = v;
    repeat (4) @(posedge clk_in);
    #1;
  endtask : pin
  initial begin
    #400us;
    bad_count++;
    give_verdict;
  end
  initial begin
    logic [29:0] got;
    repeat (8) @(posedge clk_in);
    #1 rstn_in = 1'b1;
    pin(1'b1);
    `CHK(on, 1'b1)
    for (int p = 0; p < 16; p++) begin
      wr(p, 1'b0);
      `CHK(gp, 4'(exp_port))
    end
    // Thirteen-bit frame must be ignored
    u_host.send({1'b0, 4'h5, 6'h3F, 2'b00}, 13);
    repeat (8) @(posedge clk_in);
    `CHK(gp, 4'(exp_port))
    $display("test ports done");
    wr(9, 1'b1);
    `CHK(segoff, 1'b1)
    for (int n = 0; n < 2; n++) begin
      seed = xs(seed);
      keys = seed[29:0];
      repeat (3200) @(posedge clk_in);
      `CHK(kd, keys)
      u_host.fetch(got);
      `CHK(got, keys)
    end
    $display("test keys done");
    pin(1'b0);
    `CHK(on, 1'b0)
    `CHK(segoff, 1'b0)
    `CHK(segs, {60{1'b1}})
    `CHK(bp, 10'h3FF)
    `CHK(gp, 4'h0)
    `CHK(scan, 6'h00)
    `CHK(kd, 30'h0)
    u_host.fetch(got);
    `CHK(got, 30'h0)
    wr(6, 1'b0);
    `CHK(gp, 4'h0)
    pin(1'b1);
    `CHK(gp, 4'(exp_port))
    `CHK(on, 1'b1)
    repeat (3200) @(posedge clk_in);
    `CHK(kd, keys)
    $display("test blanking done");
    give_verdict;
  end
endmodule : display_inhibit_control_bench
